/* shared/esbtc_defines.vh */
`ifndef ESBTC_DEFINES_VH
`define ESBTC_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ESB_ADDR_WIDTHS 32'h78100000
`define ESB_ADDR_ROM 32'h78100004
`define ESB_ADDR_SRAM 32'h78100008
`define ESB_ADDR_IO0 32'h7810000c
`define ESB_ADDR_IO1 32'h78100010
`define ESB_ADDR_DRAM 32'h78180000

// ----------------------------------------
// field positions
// ----------------------------------------
`define ESB_TYPE_MSB 2
`define ESB_TYPE_LSB 0
`define ESB_PAGE_BIT 4
`define ESB_SRAMBW_MSB 5
`define ESB_SRAMBW_LSB 4
`define ESB_BUSY_BIT 0
`define ESB_DRAMBW_MSB 1
`define ESB_DRAMBW_LSB 0

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define ESB_TYPE_RST 3'h7
`define ESB_PAGE_RST 1'h0
`define ESB_BW_NONE 2'h0
`define ESB_BW_8 2'h1
`define ESB_BW_16 2'h2
`define ESB_SRAMBW_RST 2'h2
`define ESB_DRAMBW_RST 2'h0
`define ESB_AREA_SRAM 2'h0
`define ESB_AREA_IO0 2'h1
`define ESB_AREA_IO1 2'h2
`define ESB_AREA_DRAM 2'h3

// ----------------------------------------
// timing tables, entry for code 7 first
// ----------------------------------------
`define ESB_SRAM_SETUP_TBL {3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1}
`define ESB_SRAM_STB_TBL {5'h10, 5'h0d, 5'h0a, 5'h08, 5'h05, 5'h03, 5'h02, 5'h01}
`define ESB_SRAM_OFF_TBL {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h3, 4'h2, 4'h1}
`define ESB_SRAM_BURST_TBL {4'h9, 4'h7, 4'h6, 4'h5, 4'h3, 4'h3, 4'h2, 4'h1}
`define ESB_IO_SETUP_TBL {3'h4, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1}
`define ESB_IO_STB_TBL {5'h18, 5'h14, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, 5'h01}
`define ESB_IO_OFF_TBL {4'hb, 4'h9, 4'h8, 4'h7, 4'h5, 4'h4, 4'h3, 4'h1}
`define ESB_IO_BURST_LEN 4'h1

`endif

/* logic/esbtc_cycle_seq.v */
`timescale 1ns/1ns
`include "esbtc_defines.vh"

module esbtc_cycle_seq (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire start,
	input wire write,
	input wire sel_b,
	input wire page_hit,
	input wire [2:0] setup_len,
	input wire [4:0] strobe_len,
	input wire [3:0] off_len,
	input wire [3:0] burst_len,
	input wire wait_in,
	output reg idle_ff,
	output reg sel_a_n_ff,
	output reg sel_b_n_ff,
	output reg oe_n_ff,
	output reg we_n_ff,
	output reg done_ff
);

// ----------------------------------------
// phases
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_SETUP = 4'h2;
localparam [3:0] ST_STROBE = 4'h4;
localparam [3:0] ST_OFF = 4'h8;

reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [4:0] cnt_ff;
reg [4:0] nxt_cnt;
reg write_ff;
reg sel_b_ff;
reg nxt_done;

always @* begin
	nxt_state = state_ff;
	nxt_cnt = cnt_ff;
	nxt_done = 1'b0;
	case (state_ff)
		ST_IDLE: begin
			if (start && page_hit) begin
				// page access skips address setup
				nxt_state = ST_STROBE;
				nxt_cnt = {1'b0, burst_len} - 5'h01;
			end else if (start) begin
				nxt_state = ST_SETUP;
				nxt_cnt = {2'h0, setup_len} - 5'h01;
			end
		end
		ST_SETUP: begin
			if (cnt_ff == 5'h00) begin
				nxt_state = ST_STROBE;
				nxt_cnt = strobe_len - 5'h01;
			end else begin
				nxt_cnt = cnt_ff - 5'h01;
			end
		end
		ST_STROBE: begin
			if (wait_in) begin
				nxt_cnt = cnt_ff;
			end else if (cnt_ff == 5'h00) begin
				nxt_state = ST_OFF;
				nxt_cnt = {1'b0, off_len} - 5'h01;
			end else begin
				nxt_cnt = cnt_ff - 5'h01;
			end
		end
		ST_OFF: begin
			if (cnt_ff == 5'h00) begin
				nxt_state = ST_IDLE;
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff - 5'h01;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
			nxt_cnt = 5'h00;
		end
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_ff <= ST_IDLE;
		cnt_ff <= 5'h00;
		write_ff <= 1'b0;
		sel_b_ff <= 1'b0;
		idle_ff <= 1'b1;
		sel_a_n_ff <= 1'b1;
		sel_b_n_ff <= 1'b1;
		oe_n_ff <= 1'b1;
		we_n_ff <= 1'b1;
		done_ff <= 1'b0;
	end else if (ce) begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		done_ff <= nxt_done;
		if (start && state_ff == ST_IDLE) begin
			write_ff <= write;
			sel_b_ff <= sel_b;
		end
		idle_ff <= (nxt_state == ST_IDLE);
		// one timing set drives whichever select of the bank is chosen
		sel_a_n_ff <= (nxt_state == ST_IDLE) ||
			(state_ff == ST_IDLE ? sel_b : sel_b_ff);
		sel_b_n_ff <= (nxt_state == ST_IDLE) ||
			!(state_ff == ST_IDLE ? sel_b : sel_b_ff);
		oe_n_ff <= !(nxt_state == ST_STROBE) ||
			(state_ff == ST_IDLE ? write : write_ff);
		we_n_ff <= !(nxt_state == ST_STROBE) ||
			!(state_ff == ST_IDLE ? write : write_ff);
	end
end

endmodule // esbtc_cycle_seq

/* logic/esbtc_ctrl.v */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "esbtc_defines.vh"

module esbtc_ctrl (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_ff,
	output reg pready_ff,
	output reg pslverr_ff,
	input wire mem_req,
	input wire [1:0] mem_area,
	input wire mem_write,
	input wire mem_sel_b,
	input wire mem_burst,
	input wire mem_from_dma,
	output reg mem_busy_ff,
	output reg mem_done_ff,
	output reg mem_err_ff,
	output reg mem_abort_ff,
	output reg dram_req_ff,
	output reg rom_page_mode_ff,
	output reg [1:0] dram_bus_width_ff,
	input wire bank0_wait_in,
	input wire bank1_wait_in,
	output wire sram_select_n,
	output wire sram_oe_n,
	output wire sram_we_n,
	output wire bank0_select_a_n,
	output wire bank0_select_b_n,
	output wire bank0_oe_n,
	output wire bank0_we_n,
	output wire bank1_select_a_n,
	output wire bank1_select_b_n,
	output wire bank1_oe_n,
	output wire bank1_we_n
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [2:0] sram_timing_code_ff;
reg sram_page_ff;
reg [2:0] bank0_timing_code_ff;
reg [2:0] bank1_timing_code_ff;
reg [1:0] sram_bus_width_ff;
reg sram_last_ff;

wire acc = psel && penable;
wire wr_take = acc && pwrite && pready_ff;
wire hit_widths = (paddr == `ESB_ADDR_WIDTHS);
wire hit_rom = (paddr == `ESB_ADDR_ROM);
wire hit_sram = (paddr == `ESB_ADDR_SRAM);
wire hit_io0 = (paddr == `ESB_ADDR_IO0);
wire hit_io1 = (paddr == `ESB_ADDR_IO1);
wire hit_dram = (paddr == `ESB_ADDR_DRAM);
wire hit_any = hit_widths || hit_rom || hit_sram || hit_io0 || hit_io1 || hit_dram;

// ----------------------------------------
// read mux
// ----------------------------------------
reg [31:0] nxt_rdata;

always @* begin
	nxt_rdata = 32'h00000000;
	if (hit_widths) begin
		nxt_rdata[`ESB_SRAMBW_MSB:`ESB_SRAMBW_LSB] = sram_bus_width_ff;
		nxt_rdata[`ESB_BUSY_BIT] = mem_busy_ff;
	end else if (hit_rom) begin
		nxt_rdata[`ESB_PAGE_BIT] = rom_page_mode_ff;
	end else if (hit_sram) begin
		nxt_rdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB] = sram_timing_code_ff;
		nxt_rdata[`ESB_PAGE_BIT] = sram_page_ff;
	end else if (hit_io0) begin
		nxt_rdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB] = bank0_timing_code_ff;
	end else if (hit_io1) begin
		nxt_rdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB] = bank1_timing_code_ff;
	end else if (hit_dram) begin
		nxt_rdata[`ESB_DRAMBW_MSB:`ESB_DRAMBW_LSB] = dram_bus_width_ff;
	end
end

// ----------------------------------------
// apb slave, one wait state
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_ff <= 1'b0;
		pslverr_ff <= 1'b0;
		prdata_ff <= 32'h00000000;
	end else if (ce) begin
		// ready is registered, so every transfer takes exactly one wait state
		pready_ff <= acc && !pready_ff;
		pslverr_ff <= acc && !pready_ff && !hit_any;
		if (acc && !pready_ff && !pwrite) begin
			prdata_ff <= nxt_rdata;
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rom_page_mode_ff <= `ESB_PAGE_RST;
		sram_timing_code_ff <= `ESB_TYPE_RST;
		sram_page_ff <= `ESB_PAGE_RST;
		bank0_timing_code_ff <= `ESB_TYPE_RST;
		bank1_timing_code_ff <= `ESB_TYPE_RST;
		sram_bus_width_ff <= `ESB_SRAMBW_RST;
		dram_bus_width_ff <= `ESB_DRAMBW_RST;
	end else if (ce && wr_take) begin
		// reserved write data is dropped, so those bits stay zero
		if (hit_rom) begin
			rom_page_mode_ff <= pwdata[`ESB_PAGE_BIT];
		end
		if (hit_sram) begin
			sram_timing_code_ff <= pwdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB];
			sram_page_ff <= pwdata[`ESB_PAGE_BIT];
		end
		if (hit_io0) begin
			bank0_timing_code_ff <= pwdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB];
		end
		if (hit_io1) begin
			bank1_timing_code_ff <= pwdata[`ESB_TYPE_MSB:`ESB_TYPE_LSB];
		end
		if (hit_widths) begin
			sram_bus_width_ff <= pwdata[`ESB_SRAMBW_MSB:`ESB_SRAMBW_LSB];
		end
		if (hit_dram) begin
			dram_bus_width_ff <= pwdata[`ESB_DRAMBW_MSB:`ESB_DRAMBW_LSB];
		end
	end
end

// ----------------------------------------
// timing decode
// ----------------------------------------
wire [23:0] sram_setup_tbl = `ESB_SRAM_SETUP_TBL;
wire [39:0] sram_stb_tbl = `ESB_SRAM_STB_TBL;
wire [31:0] sram_off_tbl = `ESB_SRAM_OFF_TBL;
wire [31:0] sram_burst_tbl = `ESB_SRAM_BURST_TBL;
wire [23:0] io_setup_tbl = `ESB_IO_SETUP_TBL;
wire [39:0] io_stb_tbl = `ESB_IO_STB_TBL;
wire [31:0] io_off_tbl = `ESB_IO_OFF_TBL;

wire [2:0] sram_setup = sram_setup_tbl[sram_timing_code_ff * 3 +: 3];
wire [4:0] sram_stb = sram_stb_tbl[sram_timing_code_ff * 5 +: 5];
wire [3:0] sram_off = sram_off_tbl[sram_timing_code_ff * 4 +: 4];
wire [3:0] sram_burst = sram_burst_tbl[sram_timing_code_ff * 4 +: 4];
wire [2:0] b0_setup = io_setup_tbl[bank0_timing_code_ff * 3 +: 3];
wire [4:0] b0_stb = io_stb_tbl[bank0_timing_code_ff * 5 +: 5];
wire [3:0] b0_off = io_off_tbl[bank0_timing_code_ff * 4 +: 4];
wire [2:0] b1_setup = io_setup_tbl[bank1_timing_code_ff * 3 +: 3];
wire [4:0] b1_stb = io_stb_tbl[bank1_timing_code_ff * 5 +: 5];
wire [3:0] b1_off = io_off_tbl[bank1_timing_code_ff * 4 +: 4];

// ----------------------------------------
// request dispatch
// ----------------------------------------
wire take = mem_req && !mem_busy_ff;
wire sram_absent = (sram_bus_width_ff == `ESB_BW_NONE);
wire dram_ok = (dram_bus_width_ff == `ESB_BW_16);
wire go_sram = take && (mem_area == `ESB_AREA_SRAM) && !sram_absent;
wire go_io0 = take && (mem_area == `ESB_AREA_IO0);
wire go_io1 = take && (mem_area == `ESB_AREA_IO1);
wire go_dram = take && (mem_area == `ESB_AREA_DRAM);
wire sram_bad = take && (mem_area == `ESB_AREA_SRAM) && sram_absent;
// without page mode every access is a single one
wire page_hit = sram_page_ff && mem_burst && sram_last_ff;
wire sram_done;
wire b0_done;
wire b1_done;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mem_busy_ff <= 1'b0;
		mem_done_ff <= 1'b0;
		mem_err_ff <= 1'b0;
		mem_abort_ff <= 1'b0;
		dram_req_ff <= 1'b0;
		sram_last_ff <= 1'b0;
	end else if (ce) begin
		mem_busy_ff <= (mem_busy_ff && !(sram_done || b0_done || b1_done)) ||
			go_sram || go_io0 || go_io1;
		mem_done_ff <= sram_done || b0_done || b1_done || (go_dram && dram_ok);
		mem_err_ff <= (sram_bad && mem_from_dma) || (go_dram && !dram_ok);
		mem_abort_ff <= sram_bad && !mem_from_dma;
		dram_req_ff <= go_dram && dram_ok;
		if (sram_done) begin
			sram_last_ff <= 1'b1;
		end else if (take) begin
			sram_last_ff <= 1'b0;
		end
	end
end

// ----------------------------------------
// cycle sequencers
// ----------------------------------------
esbtc_cycle_seq u_sram_seq (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.start(go_sram),
	.write(mem_write),
	.sel_b(1'b0),
	.page_hit(page_hit),
	.setup_len(sram_setup),
	.strobe_len(sram_stb),
	.off_len(sram_off),
	.burst_len(sram_burst),
	.wait_in(1'b0),
	.idle_ff(),
	.sel_a_n_ff(sram_select_n),
	.sel_b_n_ff(),
	.oe_n_ff(sram_oe_n),
	.we_n_ff(sram_we_n),
	.done_ff(sram_done)
);

esbtc_cycle_seq u_bank0_seq (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.start(go_io0),
	.write(mem_write),
	.sel_b(mem_sel_b),
	.page_hit(1'b0),
	.setup_len(b0_setup),
	.strobe_len(b0_stb),
	.off_len(b0_off),
	.burst_len(`ESB_IO_BURST_LEN),
	.wait_in(bank0_wait_in),
	.idle_ff(),
	.sel_a_n_ff(bank0_select_a_n),
	.sel_b_n_ff(bank0_select_b_n),
	.oe_n_ff(bank0_oe_n),
	.we_n_ff(bank0_we_n),
	.done_ff(b0_done)
);

esbtc_cycle_seq u_bank1_seq (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.start(go_io1),
	.write(mem_write),
	.sel_b(mem_sel_b),
	.page_hit(1'b0),
	.setup_len(b1_setup),
	.strobe_len(b1_stb),
	.off_len(b1_off),
	.burst_len(`ESB_IO_BURST_LEN),
	.wait_in(bank1_wait_in),
	.idle_ff(),
	.sel_a_n_ff(bank1_select_a_n),
	.sel_b_n_ff(bank1_select_b_n),
	.oe_n_ff(bank1_oe_n),
	.we_n_ff(bank1_we_n),
	.done_ff(b1_done)
);

endmodule // esbtc_ctrl

/* verif/esbtc_chk.sv */
`timescale 1ns/1ns
module esbtc_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata_ff,
	input wire pready_ff,
	input wire mem_req,
	input wire [1:0] mem_area,
	input wire mem_busy_ff,
	input wire mem_done_ff,
	input wire mem_err_ff,
	input wire dram_req_ff,
	input wire rom_page_mode_ff,
	input wire [1:0] dram_bus_width_ff,
	input wire bank0_wait_in,
	input wire bank0_oe_n,
	input wire bank0_select_a_n,
	input wire bank0_select_b_n
);
// ----------------------------------------
// port relations
// ----------------------------------------
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire dram_take = mem_req && !mem_busy_ff && mem_area == 2'h3;
pready_pulse_a: assert property (pready_ff |=> !pready_ff)
	else $error("ready longer than one cycle");
apb_wait_a: assert property ($rose(psel && penable) |-> !pready_ff ##1 pready_ff)
	else $error("ready not after one wait");
rsv_zero_a: assert property (pready_ff && !pwrite &&
	(paddr == 32'h78100008 || paddr == 32'h78100004) |-> prdata_ff[31:5] == 27'h0 && !prdata_ff[3])
	else $error("reserved bit read high");
rom_page_a: assert property (pready_ff && pwrite && paddr == 32'h78100004
	|=> rom_page_mode_ff == $past(pwdata[4])) else $error("rom page bit wrong");
dram_fwd_a: assert property (dram_take && dram_bus_width_ff == 2'h2
	|-> ##[1:2] (dram_req_ff && mem_done_ff)) else $error("dram not forwarded");
dram_err_a: assert property (dram_take && dram_bus_width_ff != 2'h2
	|-> ##[1:2] (mem_err_ff && !dram_req_ff)) else $error("dram error missing");
wait_hold_a: assert property (!bank0_oe_n && bank0_wait_in |=> !bank0_oe_n)
	else $error("strobe ended during wait");
sel_one_a: assert property (!bank0_select_a_n |-> bank0_select_b_n)
	else $error("both bank selects low");
strobe_sel_a: assert property (!bank0_oe_n |-> !(bank0_select_a_n && bank0_select_b_n))
	else $error("strobe without select");
endmodule // esbtc_chk

bind esbtc_ctrl esbtc_chk i_chk (.*);

/* verif/esbtc_mem_model.sv */
`timescale 1ns/1ns
module esbtc_mem_model (
	input wire pclk,
	input wire presetn,
	input wire [1:0] wait_len,
	input wire bank0_oe_n,
	input wire bank0_we_n,
	input wire bank1_oe_n,
	input wire bank1_we_n,
	output reg bank0_wait_in,
	output reg bank1_wait_in
);
// ----------------------------------------
// one wait line per bank, shared by both selects
// ----------------------------------------
reg [1:0] cnt0_ff, cnt1_ff;
wire stb0 = !(bank0_oe_n && bank0_we_n);
wire stb1 = !(bank1_oe_n && bank1_we_n);
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt0_ff <= 2'h0;
		cnt1_ff <= 2'h0;
		bank0_wait_in <= 1'b0;
		bank1_wait_in <= 1'b0;
	end else begin
		bank0_wait_in <= stb0 && cnt0_ff < wait_len;
		bank1_wait_in <= stb1 && cnt1_ff < wait_len;
		cnt0_ff <= stb0 ? cnt0_ff + {1'b0, cnt0_ff < wait_len} : 2'h0;
		cnt1_ff <= stb1 ? cnt1_ff + {1'b0, cnt1_ff < wait_len} : 2'h0;
	end
end
endmodule // esbtc_mem_model

/* verif/esbtc_ctrl_tb.sv */
`timescale 1ns/1ns
module esbtc_ctrl_tb;
// ----------------------------------------
// stimulus and expectations
// ----------------------------------------
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, er;
logic mem_req = 1'b0, mem_write = 1'b0, mem_sel_b = 1'b0, mem_burst = 1'b0, mem_from_dma = 1'b0;
logic [1:0] mem_area = 2'h0, wait_len = 2'h0;
logic [31:0] W[5];
logic ce = 1'b1;
wire [31:0] prdata_ff;
wire [1:0] dram_bus_width_ff;
wire pready_ff, pslverr_ff, mem_busy_ff, mem_done_ff, mem_err_ff, mem_abort_ff, dram_req_ff;
wire rom_page_mode_ff, bank0_wait_in, bank1_wait_in, sram_select_n, sram_oe_n, sram_we_n;
wire bank0_select_a_n, bank0_select_b_n, bank0_oe_n, bank0_we_n;
wire bank1_select_a_n, bank1_select_b_n, bank1_oe_n, bank1_we_n;
integer seed = 32'haca8, n_mismatch = 0, checks = 0, c, a, w, x, frz = 0;
localparam logic [31:0] RA[5] = '{32'h78100008, 32'h7810000c, 32'h78100010, 32'h78180000,
	32'h78100004};
// the rom register keeps only its page bit
localparam logic [31:0] RM[5] = '{32'h17, 32'h7, 32'h7, 32'h3, 32'h10};
localparam logic [31:0] RV[5] = '{32'h7, 32'h7, 32'h7, 32'h0, 32'h0};
localparam int SU[16] = '{1, 1, 1, 1, 2, 2, 2, 2, 1, 1, 1, 2, 2, 2, 3, 4};
localparam int SB[16] = '{1, 2, 3, 5, 8, 10, 13, 16, 1, 4, 6, 8, 12, 16, 20, 24};
localparam int OF[16] = '{1, 2, 3, 3, 4, 5, 6, 7, 1, 3, 4, 5, 7, 8, 9, 11};
localparam int BU[8] = '{1, 2, 3, 3, 5, 6, 7, 9};
wire stb_n = mem_area == 2'h0 ? sram_oe_n & sram_we_n :
	mem_area == 2'h1 ? bank0_oe_n & bank0_we_n : bank1_oe_n & bank1_we_n;
wire sel_n = mem_area == 2'h0 ? sram_select_n : mem_area == 2'h1 ?
	(mem_sel_b ? bank0_select_b_n : bank0_select_a_n) :
	(mem_sel_b ? bank1_select_b_n : bank1_select_a_n);
wire oth_n = mem_area == 2'h0 ? 1'b1 : mem_area == 2'h1 ?
	(mem_sel_b ? bank0_select_a_n : bank0_select_b_n) :
	(mem_sel_b ? bank1_select_a_n : bank1_select_b_n);
wire ostb_n = mem_area == 2'h0 ? (mem_write ? sram_oe_n : sram_we_n) : mem_area == 2'h1 ?
	(mem_write ? bank0_oe_n : bank0_we_n) : (mem_write ? bank1_oe_n : bank1_we_n);
esbtc_ctrl i_esbtc_ctrl (.*);
esbtc_mem_model i_esbtc_mem_model (.*);
// fixed rate, so no timing write can race a frequency change
always #50 pclk = ~pclk;
// the take edge precedes the first phase; done hand-off and the sampling edge follow the off phase
function integer dur(input integer i, input logic pg);
	dur = pg ? BU[i] + OF[i] + 3 : SU[i] + SB[i] + OF[i] + 3;
endfunction
task test_done;
	$display("checks %0d n_mismatch %0d", checks, n_mismatch);
	if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
task miss(input string m);
	n_mismatch++;
	$display("MISMATCH %0t %s", $time, m);
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	checks++;
	if (g !== e) miss($sformatf("value %h expected %h", g, e));
endtask
task chkn(input integer g, input integer e);
	checks++;
	if (g != e) miss($sformatf("cycles %0d expected %0d", g, e));
endtask
task apb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
	integer k;
	psel <= 1'b1;
	pwrite <= wr;
	paddr <= ad;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	k = 0;
	do begin
		@(posedge pclk);
		k++;
	end while (pready_ff !== 1'b1 && k < 20);
	rd = prdata_ff;
	er = {31'h0, pslverr_ff};
	psel <= 1'b0;
	penable <= 1'b0;
	if (k == 20) begin
		miss("apb hang");
		test_done;
	end
	// idle edge: a following call must not reassign psel in this step
	@(posedge pclk);
endtask
// negative en or es skips that count
task mem(input logic [1:0] ar, input logic b, input logic dma, input integer en,
	input integer es, input logic [31:0] ef);
	integer n, s, q, u, z;
	mem_area <= ar;
	mem_burst <= b;
	mem_from_dma <= dma;
	mem_write <= 1'($random(seed));
	mem_sel_b <= 1'($random(seed));
	mem_req <= 1'b1;
	n = 0;
	s = 0;
	q = 0;
	u = 0;
	z = 0;
	do begin
		@(posedge pclk);
		if (n == 0) mem_req <= 1'b0;
		// frz freezes one edge during address setup
		ce <= !(n == 0 && frz != 0);
		n++;
		s += (stb_n === 1'b0);
		q += (sel_n === 1'b0);
		u += (mem_busy_ff === 1'b1);
		z += (oth_n === 1'b0) + (ostb_n === 1'b0);
	end while ((mem_done_ff | mem_err_ff | mem_abort_ff) !== 1'b1 && n < 99);
	if (n == 99) begin
		miss("mem hang");
		test_done;
	end
	chk({28'h0, mem_done_ff, mem_err_ff, mem_abort_ff, dram_req_ff}, ef);
	chkn(z, 0);
	if (en >= 0) chkn(n, en);
	if (en >= 0) chkn(q, en - 3);
	if (en >= 0) chkn(u, en - 2);
	if (es >= 0) chkn(s, es);
endtask
initial begin
	repeat (10) @(posedge pclk);
	presetn <= 1'b1;
	for (a = 0; a < 5; a++) begin
		apb(1'b0, RA[a], 32'h0);
		chk(rd, RV[a]);
	end
	repeat (3) for (a = 0; a < 5; a++) begin
		W[a] = $random(seed) & RM[a];
		if (a == 3 && W[a] == 32'h1) W[a] = 32'h2;
		apb(1'b1, RA[a], W[a]);
		apb(1'b0, RA[a], 32'h0);
		chk(rd, W[a]);
	end
	chk({31'h0, rom_page_mode_ff}, {31'h0, W[4][4]});
	chk({30'h0, dram_bus_width_ff}, W[3]);
	apb(1'b0, 32'h78100014, 32'h0);
	chk(rd, 32'h0);
	chk(er, 32'h1);
	for (c = 0; c < 8; c++) for (a = 0; a < 3; a++) begin
		x = (a != 0) * 8 + c;
		w = (a != 0 && c != 0) ? {$random(seed)} % 4 : 0;
		frz = {$random(seed)} % 2;
		wait_len <= w[1:0];
		apb(1'b1, RA[a], c);
		mem(a[1:0], 1'($random(seed)), 1'b0, dur(x, 1'b0) + w + frz, SB[x] + w, 32'h8);
	end
	frz = 0;
	x = {$random(seed)} % 8;
	apb(1'b1, RA[0], 32'h10 | x);
	mem(2'h0, 1'b0, 1'b0, dur(x, 1'b0), SB[x], 32'h8);
	mem(2'h0, 1'b1, 1'b0, dur(x, 1'b1), BU[x], 32'h8);
	apb(1'b1, 32'h78100000, 32'h0);
	mem(2'h0, 1'b0, 1'b0, -1, -1, 32'h2);
	mem(2'h0, 1'b0, 1'b1, -1, -1, 32'h4);
	apb(1'b1, 32'h78100000, 32'h20);
	for (a = 0; a < 4; a++) if (a != 1) begin
		apb(1'b1, RA[3], a);
		mem(2'h3, 1'b0, 1'b0, -1, -1, a == 2 ? 32'h9 : 32'h4);
	end
	test_done;
end
endmodule // esbtc_ctrl_tb
